// >>> logic/fppc_param_check.sv
module fppc_param_check #(
    parameter logic [31:0] FLASH_START = fppc_pkg::FLASH_BASE,
    parameter logic [31:0] FLASH_BYTES = fppc_pkg::FLASH_SIZE
) (
    input  wire logic                   clk,         // 100 MHz system clock
    input  wire logic                   rst_n,       // Sync reset, low
    input  wire logic                   ce,          // Clock enable
    input  wire logic                   start_prog,  // Program request pulse
    input  wire logic                   start_erase, // Erase request pulse
    input  wire logic [31:0]            cpu_general_reg_zero, // Source/block
    input  wire logic [31:0]            cpu_general_reg_one,  // Destination
    input  wire logic [31:0]            cpu_frequency_parameter, // Freq word
    input  wire logic [7:0]             flash_unlock_key,     // Key register
    input  wire logic [7:0]             mem_rd_data, // Read data, 1 cycle
    output logic                        busy,        // Operation running
    output logic                        done,        // Completion pulse
    output fppc_pkg::fppc_result_t      program_result_flags, // Outcome
    output fppc_pkg::fppc_move_t        move,        // Byte move to array
    output logic                        erase_start, // Erase pulse
    output logic [3:0]                  erase_block  // Block to erase
);
    // Refuse flash windows that the unit checks below cannot describe
    if (FLASH_BYTES == 32'h0) begin
        $error("Flash window size must not be zero");
    end
    // A size or start off the unit grid would let a unit straddle the edge
    if (FLASH_BYTES[fppc_pkg::UNIT_ADDR_BITS-1:0] != '0) begin
        $error("Flash window size must be a whole number of units");
    end
    if (FLASH_START[fppc_pkg::UNIT_ADDR_BITS-1:0] != '0) begin
        $error("Flash window must start on a unit boundary");
    end
    // The window may not wrap past the top of the address space
    if ({1'b0, FLASH_START} + {1'b0, FLASH_BYTES} >
        33'h100000000) begin
        $error("Flash window runs past the top of the address space");
    end

    typedef struct packed {
        fppc_pkg::fppc_state_t  st;
        logic                   is_erase;
        logic [31:0]            dest;
        logic [31:0]            src;
        logic [31:0]            blk;
        logic [7:0]             cnt;
        logic                   rd_pending;
        logic                   busy;
        logic                   done;
        fppc_pkg::fppc_result_t res;
        fppc_pkg::fppc_move_t   mv;
        logic                   er_start;
        logic [3:0]             er_blk;
    } fppc_regs_t;

    fppc_regs_t r;
    fppc_regs_t next_r;

    // True when an address falls inside the flash window
    function automatic logic in_flash(input logic [31:0] a);
        in_flash = (a >= FLASH_START) && ((a - FLASH_START) < FLASH_BYTES);
    endfunction

    // [R1] frequency window check
    // A nonzero upper half is treated as a bad encoding as well
    function automatic logic freq_word_bad(input logic [31:0] w);
        freq_word_bad = (w[31:16] != 16'h0000) ||
                        (w[15:0] < fppc_pkg::FREQ_MIN) ||
                        (w[15:0] > fppc_pkg::FREQ_MAX);
    endfunction

    // [R5] destination range, alignment
    function automatic logic dest_addr_bad(input logic [31:0] a);
        dest_addr_bad = !in_flash(a) ||
                        (a[fppc_pkg::UNIT_ADDR_BITS-1:0] != '0);
    endfunction

    // [R8] source outside flash
    // Both ends of the unit are tried, so a source that starts below the
    // window but runs into it, or wraps round into it, is refused too
    function automatic logic src_area_bad(input logic [31:0] a);
        src_area_bad = in_flash(a) ||
                       in_flash(a + 32'(fppc_pkg::UNIT_BYTES - 1));
    endfunction

    // Check results; addresses and block latched, frequency and key read live
    logic freq_bad;
    logic dest_bad;
    logic src_bad;
    logic blk_bad;
    logic key_bad;

    always_comb begin
        // [R1] frequency window check
        freq_bad = freq_word_bad(cpu_frequency_parameter);
        // [R5] destination range, alignment
        dest_bad = dest_addr_bad(r.dest);
        // [R8] source outside flash
        src_bad  = src_area_bad(r.src);
        // [R9] erase block range
        blk_bad  = r.blk > fppc_pkg::ERASE_LAST;
        // [R11] unlock key compare
        key_bad  = flash_unlock_key != fppc_pkg::UNLOCK_KEY;
    end

    // Sequencer: latch, check, then act only on a clean result
    always_comb begin
        next_r              = r;
        next_r.done         = 1'b0;
        next_r.er_start     = 1'b0;
        next_r.mv.mem_rd_en = 1'b0;
        next_r.mv.wr_en     = 1'b0;
        next_r.rd_pending   = r.mv.mem_rd_en;
        // Byte read last cycle returns now; write it to the array.
        // The pending bit lines the write up with the memory's one-cycle
        // latency, so source byte k lands at destination byte k while ce stays high.
        if (r.rd_pending) begin
            next_r.mv.wr_en   = 1'b1;
            next_r.mv.wr_data = mem_rd_data;
            next_r.mv.wr_addr = r.dest;
            next_r.dest       = r.dest + 32'h1;
        end
        case (r.st)
            fppc_pkg::ST_IDLE: begin
                // Erase wins if both starts come together. The frequency
                // word and key are read live in the check, so hold them.
                if (start_erase) begin
                    next_r.is_erase = 1'b1;
                    next_r.blk      = cpu_general_reg_zero;
                    next_r.busy     = 1'b1;
                    next_r.st       = fppc_pkg::ST_CHECK;
                end else if (start_prog) begin
                    next_r.is_erase = 1'b0;
                    next_r.src      = cpu_general_reg_zero;
                    next_r.dest     = cpu_general_reg_one;
                    next_r.busy     = 1'b1;
                    next_r.st       = fppc_pkg::ST_CHECK;
                end
            end
            fppc_pkg::ST_CHECK: begin
                // [R13] every check is settled before any array action
                // Flags restart from zero so nothing of the last call stays
                next_r.res = '0;
                next_r.res.freq_error = freq_bad;
                if (r.is_erase) begin
                    // [R10] block-select flag
                    next_r.res.block_select_error = blk_bad;
                    // [R11] key flag before erasure
                    next_r.res.key_error = key_bad;
                end else begin
                    // [R5] write-address flag
                    next_r.res.write_address_error = dest_bad;
                    // [R8] write-data flag
                    next_r.res.write_data_error = src_bad;
                end
                // [R12] abnormal completion
                next_r.res.success_fail = freq_bad ||
                    (r.is_erase ? (blk_bad || key_bad)
                                : (dest_bad || src_bad));
                next_r.cnt = 8'h00;
                // [R13] failed check skips the array entirely
                if (next_r.res.success_fail) begin
                    next_r.st = fppc_pkg::ST_DONE;
                end else if (r.is_erase) begin
                    next_r.st = fppc_pkg::ST_ERASE;
                end else begin
                    next_r.st = fppc_pkg::ST_PROG;
                end
            end
            fppc_pkg::ST_PROG: begin
                // Limitation: the memory's read latency does not stop with
                // ce, so dropping ce while bytes are in flight loses one;
                // keep ce high for the whole of a program.
                // [R6] [R7] 128 consecutive bytes, source to destination
                if (r.cnt < 8'(fppc_pkg::UNIT_BYTES)) begin
                    next_r.mv.mem_rd_en   = 1'b1;
                    next_r.mv.mem_rd_addr = r.src;
                    next_r.src            = r.src + 32'h1;
                    next_r.cnt            = r.cnt + 8'h01;
                end else if (!r.rd_pending && !r.mv.mem_rd_en) begin
                    next_r.st = fppc_pkg::ST_DONE;
                end
            end
            fppc_pkg::ST_ERASE: begin
                // [R9] valid number selects block n
                next_r.er_start = 1'b1;
                // Range already checked, so the low four bits suffice
                next_r.er_blk   = r.blk[3:0];
                next_r.st       = fppc_pkg::ST_DONE;
            end
            fppc_pkg::ST_DONE: begin
                // Done and busy change together, so no start slips between
                next_r.done = 1'b1;
                next_r.busy = 1'b0;
                next_r.st   = fppc_pkg::ST_IDLE;
            end
            default: begin
                // An upset state code falls back to idle
                next_r.st   = fppc_pkg::ST_IDLE;
                next_r.busy = 1'b0;
            end
        endcase
    end

    // State register; clock enable freezes everything
    // Reset ignores ce so that a frozen block can still be cleared
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            r    <= '0;
            r.st <= fppc_pkg::ST_IDLE;
        end else if (ce) begin
            r <= next_r;
        end
    end

    // Every output is a register field, never logic behind one
    assign busy                 = r.busy;
    assign done                 = r.done;
    assign program_result_flags = r.res;
    assign move                 = r.mv;
    assign erase_start          = r.er_start;
    assign erase_block          = r.er_blk;
endmodule

// >>> logic/fppc_pkg.sv
// How it works
// [R1] Frequency must lie between 8 and 40 MHz; otherwise the call fails.
// [R2] Caller encodes frequency as MHz times 100 in the low 16 bits.
// [R3] Caller leaves the upper 16 bits of the frequency word at zero.
// [R4] Caller passes the multiplied CPU frequency when the multiplier is used.
// [R5] Write-address error when destination is off-array or not 128-byte aligned.
// [R6] Program writes one 128-byte unit from the aligned destination address.
// [R7] The 128 bytes are read consecutively from the source start address.
// [R8] Write-data error when the source area lies inside the flash.
// [R9] Erase block 0 to 11 selects block n; others give an error.
// [R10] Block-select error bit: 0 valid block number, 1 invalid.
// [R11] Before erasing, unlock key must hold the unlock value, else key error.
// [R12] Success/fail bit: 0 normal completion, 1 abnormal completion.
// [R13] All checks finish before any array action; a failed check leaves it.
package fppc_pkg;
    // Frequency limits in units of 10 kHz (MHz times 100)
    localparam logic [15:0] FREQ_MIN       = 16'h0320; // 8.00 MHz
    localparam logic [15:0] FREQ_MAX       = 16'h0FA0; // 40.00 MHz
    localparam int          UNIT_BYTES     = 128;
    localparam int          UNIT_ADDR_BITS = 7;
    localparam logic [31:0] ERASE_LAST     = 32'h0000000B;
    localparam logic [7:0]  UNLOCK_KEY     = 8'h5A;
    // Plain defaults for the flash window; the part may differ
    localparam logic [31:0] FLASH_BASE     = 32'h00000000;
    localparam logic [31:0] FLASH_SIZE     = 32'h00080000;

    typedef enum logic [4:0] {
        ST_IDLE  = 5'h01,
        ST_CHECK = 5'h02,
        ST_PROG  = 5'h04,
        ST_ERASE = 5'h08,
        ST_DONE  = 5'h10
    } fppc_state_t;

    // Result flags handed back to firmware
    typedef struct packed {
        logic freq_error;
        logic write_address_error;
        logic write_data_error;
        logic key_error;
        logic block_select_error;
        logic success_fail;
    } fppc_result_t;

    // Byte move towards the array
    typedef struct packed {
        logic        mem_rd_en;
        logic [31:0] mem_rd_addr;
        logic        wr_en;
        logic [31:0] wr_addr;
        logic [7:0]  wr_data;
    } fppc_move_t;
endpackage

// >>> verif/fppc_mem_model.sv
module fppc_mem_model (
    input  wire logic        clk,     // System clock
    input  wire logic        rd_en,   // Read strobe
    input  wire logic [31:0] rd_addr, // Byte address
    output logic [7:0]       rd_data  // Byte, one cycle late
);
    timeunit 1ns;
    timeprecision 1ns;
    initial rd_data = 8'h00;
    // Idle cycles show the inverse, so a stale byte never passes as fresh
    always @(posedge clk) begin
        rd_data <= rd_en ? rd_addr[7:0] ^ 8'hA5 : ~rd_data;
    end
endmodule

// >>> verif/fppc_props.sv
module fppc_props (
    input wire logic                   clk,         // Clock
    input wire logic                   rst_n,       // Reset, low
    input wire logic                   ce,          // Enable
    input wire logic                   start_prog,  // Program
    input wire logic                   start_erase, // Erase
    input wire logic                   busy,        // Running
    input wire logic                   done,        // Finished
    input wire fppc_pkg::fppc_result_t program_result_flags, // Flags
    input wire fppc_pkg::fppc_move_t   move,        // Byte move
    input wire logic                   erase_start, // Erase pulse
    input wire logic [3:0]             erase_block  // Block
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n || !ce);
    // A start is taken only while idle, the done cycle included; the sequence leaves done out
    sequence taken_s;
        (start_prog || start_erase) && !busy && !done;
    endsequence
    sequence erase_ok_s;
        start_erase && !busy && !done ##2 !program_result_flags.success_fail;
    endsequence
    busy_on_take_a: assert property (taken_s |-> ##2 busy)
        else $error("busy not raised after start");
    fail_done_a: assert property ((taken_s ##2 program_result_flags[0])
        |-> ##1 (done && !erase_start && !move.wr_en && !move.mem_rd_en))
        else $error("failed check did not end quietly");
    erase_pulse_a: assert property (erase_ok_s |-> ##1 erase_start ##1 done)
        else $error("erase pulse or done misplaced");
    erase_guard_a: assert property (erase_start |-> erase_block <= 4'hB
        && !program_result_flags.key_error && !program_result_flags[1])
        else $error("erase started despite a failed check");
    flag_or_a: assert property (program_result_flags[5:1] != 5'h00
        |-> program_result_flags.success_fail)
        else $error("error flag without fail bit");
    unit_align_a: assert property ($rose(move.wr_en)
        |-> move.wr_addr[6:0] == 7'h00)
        else $error("unit start not aligned");
    write_step_a: assert property (move.wr_en && $past(move.wr_en)
        |-> move.wr_addr == $past(move.wr_addr) + 32'h1)
        else $error("write address not consecutive");
    // Read strobe, then a cycle of data return, then the write
    read_first_a: assert property (move.wr_en
        |-> $past(move.mem_rd_en, 2))
        else $error("write without a read before it");
endmodule

bind fppc_param_check fppc_props u_props (
    .clk(clk), .rst_n(rst_n), .ce(ce), .start_prog(start_prog),
    .start_erase(start_erase), .busy(busy), .done(done), .move(move),
    .program_result_flags(program_result_flags),
    .erase_start(erase_start), .erase_block(erase_block)
);

// >>> verif/tb_flash_program_param_check.sv
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin \
    bad_count++; $display("mismatch at %0t: value differs", $time); end end
module tb_flash_program_param_check;
    timeunit 1ns;
    timeprecision 1ns;
    logic                   clk, rst_n, ce, start_prog, start_erase, p;
    logic [31:0]            r0, r1, freq;
    logic [7:0]             key, rd_data;
    logic                   busy, done, erase_start;
    logic [3:0]             erase_block;
    fppc_pkg::fppc_result_t flags;
    fppc_pkg::fppc_move_t   move;
    int                     bad_count, samples_checked;
    logic [31:0]            seed = 32'h00000055;
    // Program corner cases: source and destination pairs
    logic [31:0]            r0_tab[5] = '{32'h00080000, 32'h00100000,
        32'h00100000, 32'h0007FFFF, 32'hFFFFFFC0};
    logic [31:0]            r1_tab[5] = '{32'h00000080, 32'h00000081,
        32'h00080000, 32'h0007FF80, 32'h00000100};
    logic [31:0]            f_tab[5] = '{32'h0000031F, 32'h00000320,
        32'h00000FA0, 32'h00000FA1, 32'h00010CE4};
    fppc_param_check DUT (.clk(clk), .rst_n(rst_n), .ce(ce),
        .start_prog(start_prog), .start_erase(start_erase),
        .cpu_general_reg_zero(r0), .cpu_general_reg_one(r1),
        .cpu_frequency_parameter(freq), .flash_unlock_key(key),
        .mem_rd_data(rd_data), .busy(busy), .done(done),
        .program_result_flags(flags), .move(move),
        .erase_start(erase_start), .erase_block(erase_block));
    fppc_mem_model u_mem (.clk(clk), .rd_en(move.mem_rd_en),
        .rd_addr(move.mem_rd_addr), .rd_data(rd_data));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // True when an address lies in the flash window
    function automatic logic flash_hit(logic [31:0] a);
        return a - fppc_pkg::FLASH_BASE < fppc_pkg::FLASH_SIZE;
    endfunction
    // Flags a correct device reports for the current parameters
    function automatic fppc_pkg::fppc_result_t want(logic prog);
        fppc_pkg::fppc_result_t e;
        e = '0;
        e.freq_error = freq[31:16] != 16'h0000 ||
            freq[15:0] < fppc_pkg::FREQ_MIN || freq[15:0] > fppc_pkg::FREQ_MAX;
        if (prog) begin
            e.write_address_error = !flash_hit(r1) || r1[6:0] != 7'h00;
            // The whole 128-byte source unit must stay clear of the flash
            e.write_data_error = flash_hit(r0) || flash_hit(r0 + 32'h7F);
        end else begin
            e.key_error = key != fppc_pkg::UNLOCK_KEY;
            e.block_select_error = r0 > fppc_pkg::ERASE_LAST;
        end
        e.success_fail = e[5:1] != 5'h00;
        return e;
    endfunction
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // One operation; an erase start is injected while a passing program is busy, to be ignored
    task automatic run(input logic prog);
        fppc_pkg::fppc_result_t e;
        int wr, es, i;
        e = want(prog);
        wr = 0;
        es = 0;
        @(negedge clk);
        start_prog = prog;
        start_erase = !prog;
        @(negedge clk);
        start_prog = 1'b0;
        for (i = 0; i < 300 && done !== 1'b1; i++) begin
            start_erase = prog && i == 8;
            // One frozen cycle in the check of erase block 5 only delays it
            ce = prog || i != 0 || r0 != 32'h5;
            @(negedge clk);
            if (done !== 1'b1) `CHK(busy, 1'b1)
            if (move.wr_en === 1'b1) begin
                `CHK(move.wr_addr, r1 + wr)
                `CHK(move.wr_data, 8'(r0 + wr) ^ 8'hA5)
            end
            wr += move.wr_en;
            es += erase_start;
        end
        if (i == 300) begin
            bad_count++;
            tally_and_finish();
        end
        `CHK(flags, e)
        `CHK(busy, 1'b0)
        `CHK(wr, (prog && !e[0]) ? fppc_pkg::UNIT_BYTES : 0)
        `CHK(es, int'(!prog && !e[0]))
        if (!prog && !e[0]) `CHK(erase_block, r0[3:0])
    endtask
    initial begin
        {rst_n, start_prog, start_erase, ce} = 4'h1;
        {r0, r1} = '0;
        key = fppc_pkg::UNLOCK_KEY;
        // 33.00 MHz CPU clock after multiplying, upper half zero
        freq = 32'h00000CE4;
        repeat (2) @(negedge clk);
        rst_n = 1'b1;
        `CHK(flags, 6'h00)
        foreach (r0_tab[k]) begin
            {r0, r1} = {r0_tab[k], r1_tab[k]};
            run(1'b1);
        end
        for (int b = 0; b < 14; b++) begin
            r0 = b;
            run(1'b0);
        end
        foreach (f_tab[k]) begin
            freq = f_tab[k];
            run(1'b0);
        end
        key = 8'hA5;
        run(1'b0);
        repeat (30) begin
            p = rnd() % 5 == 0;
            r0 = p ? 32'h00200000 + (rnd() & 32'hFFFF) : rnd() & 32'h8000000F;
            r1 = rnd() & 32'h000FFF81;
            key = rnd() % 4 == 0 ? 8'(rnd()) : fppc_pkg::UNLOCK_KEY;
            freq = 32'h00000200 + rnd() % 32'h1000;
            run(p);
        end
        tally_and_finish();
    end
endmodule
